// File: ssp_pkg.sv
// Package with register map, field positions and reset values of the serial port
package ssp_pkg;
    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam int ADDR_W = 4;
    localparam logic [3:0] OFF_CTRL1 = 4'h0;
    localparam logic [3:0] OFF_CTRL2 = 4'h1;
    localparam logic [3:0] OFF_BAUD = 4'h2;
    localparam logic [3:0] OFF_FLAGS = 4'h3;
    localparam logic [3:0] OFF_RSV4 = 4'h4;
    localparam logic [3:0] OFF_DATA = 4'h5;
    localparam logic [3:0] OFF_RSV6 = 4'h6;
    localparam logic [3:0] OFF_RSV7 = 4'h7;
    localparam logic [3:0] OFF_EVT = 4'h8;
    localparam logic [3:0] OFF_EVT_MASK = 4'h9;
    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int B_IRQ_EN = 7;
    localparam int B_ENABLE = 6;
    localparam int B_TX_IRQ_EN = 5;
    localparam int B_MASTER = 4;
    localparam int B_CLOCK_POLARITY_SELECT = 3;
    localparam int B_CLOCK_PHASE_SELECT = 2;
    localparam int B_SEL_OE = 1;
    localparam int B_LSB_FIRST = 0;
    localparam int B_FAULT_EN = 4;
    localparam int B_BIDIR_OE = 3;
    localparam int B_WAIT_HALT = 1;
    localparam int B_BIDIR = 0;
    localparam int B_DONE_FLAG = 7;
    localparam int B_TX_EMPTY = 5;
    localparam int B_FAULT = 4;
    localparam int E_DONE = 0;
    localparam int E_FAULT = 1;
    localparam int E_TX_EMPTY = 2;
    localparam int EVT_W = 3;
    // ************************************************************
    // Reset values, write masks, counts
    // ************************************************************
    localparam logic [7:0] CTRL1_RST = 8'h04;
    localparam logic [7:0] CTRL2_RST = 8'h00;
    localparam logic [7:0] CTRL2_WMASK = 8'h1b;
    localparam logic [7:0] BAUD_RST = 8'h00;
    localparam logic [7:0] BAUD_WMASK = 8'h77;
    localparam logic [2:0] EVT_RST = 3'h0;
    localparam logic [4:0] LAST_EDGE = 5'h10;
    localparam int DIV_W = 11;
    typedef enum logic {SSP_IDLE, SSP_RUN} ssp_state_type;
endpackage

// File: ssp_sync_if.sv
// Interface carrying raw pin levels into the synchroniser and synced levels back
`timescale 1ns/1ps
interface ssp_sync_if #(parameter int W = 4);
    logic [W-1:0] raw;
    logic [W-1:0] synced;
    modport sync_side (input raw, output synced);
    modport user_side (output raw, input synced);
endinterface

// File: ssp_sync.sv
// Two-stage synchroniser for the serial pins
`timescale 1ns/1ps
module ssp_sync (
    input wire logic clk,
    input wire logic rst,
    ssp_sync_if.sync_side pins
);
    logic [$bits(pins.raw)-1:0] meta_q;
    logic [$bits(pins.raw)-1:0] stable_q;

    // ************************************************************
    // Synchroniser stages
    // ************************************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_q <= '0;
            stable_q <= '0;
        end else begin
            meta_q <= pins.raw;
            stable_q <= meta_q;
        end
    end

    assign pins.synced = stable_q;
endmodule // ssp_sync

// File: spi_serial_port.sv
// Byte-wide synchronous serial port, master or slave, with register bank
// What this block does
// - In wait mode with halt select clear, run exactly as in run mode.
// - In wait mode with halt select set, stop making the serial clock.
// - A halted master freezes its transfer and resumes from the same point.
// - Stop mode halts a master port; its transfer resumes afterwards.
// - A slave keeps shifting its byte through wait and stop modes.
// - Master drives data out on mosi; slave takes data from mosi.
// - Slave drives data out on miso; master takes data from miso.
// - Master may drive select out; slave takes select as an input.
// - Master drives the serial clock; slave shifts on the received clock.
// - Registers decode at base plus offset, ten bytes, data at offset five.
// - Reserved bits read zero and writes to them change nothing.
// - Writes to the flags register are ignored.
// - Reading reserved offset six returns zero.
// - Clearing the enable bit idles the port and clears all flags.
// - Phase select 0 samples on odd clock edges, 1 on even edges.
// - Polarity select 0 idles the clock low, 1 idles it high.
`timescale 1ns/1ps
module spi_serial_port (
    input wire logic clk,
    input wire logic rst,
    input wire logic [ssp_pkg::ADDR_W-1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire logic wait_mode,
    input wire logic stop_mode,
    input wire logic mosi_i,
    output logic mosi_o,
    output logic mosi_oe,
    input wire logic miso_i,
    output logic miso_o,
    output logic miso_oe,
    input wire logic ss_n_i,
    output logic ss_n_o,
    output logic ss_n_oe,
    input wire logic sck_i,
    output logic sck_o,
    output logic sck_oe,
    output logic irq
);
    // ************************************************************
    // Declarations
    // ************************************************************
    ssp_sync_if #(.W(4)) pin_if ();
    ssp_pkg::ssp_state_type state_q;
    ssp_pkg::ssp_state_type state_d;
    logic [7:0] ctrl1_q;
    logic [7:0] ctrl2_q;
    logic [7:0] baud_q;
    logic [7:0] tx_buf_q;
    logic tx_full_q;
    logic [7:0] rx_q;
    logic [7:0] sh_q;
    logic [7:0] sh_d;
    logic out_q;
    logic out_d;
    logic [4:0] ecnt_q;
    logic [ssp_pkg::DIV_W-1:0] div_q;
    logic lvl_q;
    logic lvl_d;
    logic done_flag_q;
    logic fault_q;
    logic [ssp_pkg::EVT_W-1:0] evt_q;
    logic [ssp_pkg::EVT_W-1:0] evt_mask_q;
    logic sck_p_q;
    logic ss_p_q;
    logic [7:0] rdata_q;
    logic mosi_o_q;
    logic miso_o_q;
    logic mosi_oe_q;
    logic miso_oe_q;
    logic ss_n_o_q;
    logic ss_n_oe_q;
    logic sck_o_q;
    logic sck_oe_q;
    logic irq_q;

    // ************************************************************
    // Helper functions
    // ************************************************************
    function automatic logic head_bit(input logic lsb_first, input logic [7:0] v);
        head_bit = lsb_first ? v[0] : v[7];
    endfunction

    function automatic logic [ssp_pkg::DIV_W-1:0] half_period(input logic [7:0] b);
        logic [ssp_pkg::DIV_W-1:0] pre;
        pre = {{(ssp_pkg::DIV_W-3){1'b0}}, b[6:4]} + {{(ssp_pkg::DIV_W-1){1'b0}}, 1'b1};
        half_period = pre << b[2:0];
    endfunction

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    assign pin_if.raw = {sck_i, ss_n_i, mosi_i, miso_i};

    ssp_sync u_sync (
        .clk(clk),
        .rst(rst),
        .pins(pin_if.sync_side)
    );

    wire sck_s = pin_if.synced[3];
    wire ss_n_s = pin_if.synced[2];
    wire mosi_s = pin_if.synced[1];
    wire miso_s = pin_if.synced[0];

    // ************************************************************
    // Configuration fields
    // ************************************************************
    wire en = ctrl1_q[ssp_pkg::B_ENABLE];
    wire master = ctrl1_q[ssp_pkg::B_MASTER];
    wire clock_polarity_select = ctrl1_q[ssp_pkg::B_CLOCK_POLARITY_SELECT];
    wire clock_phase_select = ctrl1_q[ssp_pkg::B_CLOCK_PHASE_SELECT];
    wire sel_oe = ctrl1_q[ssp_pkg::B_SEL_OE];
    wire lsb_first = ctrl1_q[ssp_pkg::B_LSB_FIRST];
    wire fault_en = ctrl2_q[ssp_pkg::B_FAULT_EN];
    wire wait_halt_select = ctrl2_q[ssp_pkg::B_WAIT_HALT];
    wire running = state_q == ssp_pkg::SSP_RUN;

    // ************************************************************
    // Register decode
    // ************************************************************
    wire wr_ctrl1 = wr && addr == ssp_pkg::OFF_CTRL1;
    wire wr_ctrl2 = wr && addr == ssp_pkg::OFF_CTRL2;
    wire wr_baud = wr && addr == ssp_pkg::OFF_BAUD;
    wire wr_data = wr && addr == ssp_pkg::OFF_DATA;
    wire wr_mask = wr && addr == ssp_pkg::OFF_EVT_MASK;
    wire rd_data = rd && addr == ssp_pkg::OFF_DATA;
    wire rd_evt = rd && addr == ssp_pkg::OFF_EVT;
    wire [7:0] ctrl2_w = wdata & ssp_pkg::CTRL2_WMASK;
    wire [7:0] baud_w = wdata & ssp_pkg::BAUD_WMASK;
    wire cfg_change = (wr_ctrl1 && wdata != ctrl1_q) || (wr_ctrl2 && ctrl2_w != ctrl2_q);

    // ************************************************************
    // Mode, halt and abort conditions
    // ************************************************************
    // Master halts in stop, or in wait with halt select; a slave never halts
    wire halt = master && (stop_mode || (wait_mode && wait_halt_select));
    wire fault_evt = en && master && fault_en && !sel_oe && !ss_n_s;
    wire kill = !en || cfg_change || fault_evt;
    wire ss_rise = !master && ss_n_s && running;

    // ************************************************************
    // Edge generation
    // ************************************************************
    wire [ssp_pkg::DIV_W-1:0] half = half_period(baud_q);
    wire div_wrap = div_q == half - {{(ssp_pkg::DIV_W-1){1'b0}}, 1'b1};
    wire m_tick = master && running && !halt && div_wrap;
    wire s_tick = !master && running && !ss_n_s && sck_s != sck_p_q;
    wire m_start = en && master && !running && tx_full_q && !halt && !kill;
    wire s_start = en && !master && !ss_n_s && ss_p_q && !kill;
    wire start = m_start || s_start;
    wire tick = master ? m_tick : s_tick;
    wire [4:0] edge_n = ecnt_q + 5'h01;
    wire sample = tick && (edge_n[0] ^ clock_phase_select);
    wire shift_out = tick && !(edge_n[0] ^ clock_phase_select);
    wire done = tick && edge_n == ssp_pkg::LAST_EDGE;
    wire rx_bit = master ? miso_s : mosi_s;
    wire [7:0] load_val = tx_full_q ? tx_buf_q : 8'hff;

    // ************************************************************
    // Shifter next values
    // ************************************************************
    always_comb begin
        sh_d = sh_q;
        out_d = out_q;
        if (start) begin
            sh_d = load_val;
            if (!clock_phase_select) begin
                out_d = head_bit(lsb_first, load_val);
            end
        end else if (sample) begin
            sh_d = lsb_first ? {rx_bit, sh_q[7:1]} : {sh_q[6:0], rx_bit};
        end else if (shift_out) begin
            out_d = head_bit(lsb_first, sh_q);
        end
    end

    always_comb begin
        state_d = state_q;
        if (kill || done || ss_rise) begin
            state_d = ssp_pkg::SSP_IDLE;
        end else if (start) begin
            state_d = ssp_pkg::SSP_RUN;
        end
    end

    assign lvl_d = (kill || start || !running) ? 1'b0 : (m_tick ? !lvl_q : lvl_q);

    // ************************************************************
    // Transfer state
    // ************************************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= ssp_pkg::SSP_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            sh_q <= 8'h00;
            out_q <= 1'b0;
        end else begin
            sh_q <= sh_d;
            out_q <= out_d;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || start) begin
            ecnt_q <= 5'h00;
        end else if (tick) begin
            ecnt_q <= edge_n;
        end
    end

    // Divider holds its count while halted so the bit resumes in place
    always_ff @(posedge clk) begin
        if (rst || start || !running) begin
            div_q <= '0;
        end else if (master && !halt) begin
            div_q <= div_wrap ? '0 : div_q + {{(ssp_pkg::DIV_W-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            lvl_q <= 1'b0;
            sck_p_q <= 1'b0;
            ss_p_q <= 1'b1;
        end else begin
            lvl_q <= lvl_d;
            sck_p_q <= sck_s;
            ss_p_q <= ss_n_s;
        end
    end

    // ************************************************************
    // Data buffers
    // ************************************************************
    always_ff @(posedge clk) begin
        if (rst || !en) begin
            tx_full_q <= 1'b0;
        end else if (start && tx_full_q) begin
            tx_full_q <= 1'b0;
        end else if (wr_data) begin
            tx_full_q <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            tx_buf_q <= 8'h00;
        end else if (wr_data && !tx_full_q) begin
            tx_buf_q <= wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rx_q <= 8'h00;
        end else if (done) begin
            rx_q <= sh_d;
        end
    end

    // ************************************************************
    // Control registers
    // ************************************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl1_q <= ssp_pkg::CTRL1_RST;
        end else if (wr_ctrl1) begin
            ctrl1_q <= wdata;
        end else if (fault_evt) begin
            ctrl1_q[ssp_pkg::B_MASTER] <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl2_q <= ssp_pkg::CTRL2_RST;
        end else if (wr_ctrl2) begin
            ctrl2_q <= ctrl2_w;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            baud_q <= ssp_pkg::BAUD_RST;
        end else if (wr_baud) begin
            baud_q <= baud_w;
        end
    end

    // ************************************************************
    // Status flags
    // ************************************************************
    always_ff @(posedge clk) begin
        if (rst || !en) begin
            done_flag_q <= 1'b0;
        end else if (done) begin
            done_flag_q <= 1'b1;
        end else if (rd_data) begin
            done_flag_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || !en) begin
            fault_q <= 1'b0;
        end else if (fault_evt) begin
            fault_q <= 1'b1;
        end else if (wr_ctrl1) begin
            fault_q <= 1'b0;
        end
    end

    wire [7:0] flags_val = {done_flag_q, 1'b0, en && !tx_full_q, fault_q, 4'h0};
    wire [ssp_pkg::EVT_W-1:0] evt_set = {start && tx_full_q, fault_evt, done};

    // ************************************************************
    // Interrupt events
    // ************************************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            evt_q <= ssp_pkg::EVT_RST;
        end else begin
            evt_q <= (rd_evt ? ssp_pkg::EVT_RST : evt_q) | evt_set;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            evt_mask_q <= ssp_pkg::EVT_RST;
        end else if (wr_mask) begin
            evt_mask_q <= wdata[ssp_pkg::EVT_W-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(evt_q & evt_mask_q);
        end
    end

    // ************************************************************
    // Read path
    // ************************************************************
    // Flags and reserved offsets have no write path at all
    wire [7:0] rd_mux =
        addr == ssp_pkg::OFF_CTRL1 ? ctrl1_q :
        addr == ssp_pkg::OFF_CTRL2 ? ctrl2_q :
        addr == ssp_pkg::OFF_BAUD ? baud_q :
        addr == ssp_pkg::OFF_FLAGS ? flags_val :
        addr == ssp_pkg::OFF_DATA ? rx_q :
        addr == ssp_pkg::OFF_EVT ? {5'h00, evt_q} :
        addr == ssp_pkg::OFF_EVT_MASK ? {5'h00, evt_mask_q} :
        8'h00;

    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rd ? rd_mux : 8'h00;
        end
    end

    // ************************************************************
    // Pin drivers
    // ************************************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            mosi_o_q <= 1'b0;
            miso_o_q <= 1'b0;
            sck_o_q <= 1'b0;
            ss_n_o_q <= 1'b1;
        end else begin
            mosi_o_q <= out_d;
            miso_o_q <= out_d;
            sck_o_q <= clock_polarity_select ^ lvl_d;
            // Select stays low through the last clock edge of the byte
            ss_n_o_q <= !(master && (state_d == ssp_pkg::SSP_RUN || done));
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            mosi_oe_q <= 1'b0;
            miso_oe_q <= 1'b0;
            sck_oe_q <= 1'b0;
            ss_n_oe_q <= 1'b0;
        end else begin
            mosi_oe_q <= en && master;
            miso_oe_q <= en && !master && !ss_n_s;
            sck_oe_q <= en && master;
            ss_n_oe_q <= en && master && fault_en && sel_oe;
        end
    end

    assign rdata = rdata_q;
    assign mosi_o = mosi_o_q;
    assign miso_o = miso_o_q;
    assign mosi_oe = mosi_oe_q;
    assign miso_oe = miso_oe_q;
    assign sck_o = sck_o_q;
    assign sck_oe = sck_oe_q;
    assign ss_n_o = ss_n_o_q;
    assign ss_n_oe = ss_n_oe_q;
    assign irq = irq_q;
endmodule // spi_serial_port

// File: ssp_properties.sv
// Port timing checker of the serial port
`timescale 1ns/1ps
module ssp_properties (
    input wire logic clk,
    input wire logic rst,
    input wire logic [ssp_pkg::ADDR_W-1:0] addr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    input wire logic stop_mode,
    input wire logic ss_n_i,
    input wire logic mosi_o,
    input wire logic miso_oe,
    input wire logic ss_n_o,
    input wire logic ss_n_oe,
    input wire logic sck_o,
    input wire logic sck_oe
);
    // ****************
    // Properties
    // ****************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_rdata_one_cycle: assert property (!$past(rd) |-> rdata == 8'h00)
        else $error("read data outside answer cycle");
    a_flags_rsvd_zero: assert property ($past(rd) && $past(addr) == ssp_pkg::OFF_FLAGS
        |-> rdata[6] == 1'b0 && rdata[3:0] == 4'h0)
        else $error("flags reserved bits not zero");
    a_ctrl2_rsvd_zero: assert property ($past(rd) && $past(addr) == ssp_pkg::OFF_CTRL2
        |-> (rdata & ~ssp_pkg::CTRL2_WMASK) == 8'h00)
        else $error("control two reserved bits not zero");
    a_rsv6_reads_zero: assert property ($past(rd) && $past(addr) == ssp_pkg::OFF_RSV6
        |-> rdata == 8'h00)
        else $error("offset six not zero");
    a_slave_sel_in: assert property (miso_oe |-> !$past(ss_n_i, 2) || !$past(ss_n_i, 3))
        else $error("slave output without select");
    a_roles_exclusive: assert property (miso_oe |-> !sck_oe)
        else $error("slave and master drive at once");
    a_sel_out_master: assert property (ss_n_oe |-> sck_oe)
        else $error("select driven outside master");
    a_stop_freezes: assert property (stop_mode && $past(stop_mode) && $past(stop_mode, 2)
        && sck_oe |-> $stable(sck_o))
        else $error("clock moved in stop mode");
    a_mosi_on_edge: assert property (!ss_n_o && $past(!ss_n_o) && $changed(mosi_o)
        |-> $changed(sck_o))
        else $error("data changed off clock edge");
endmodule // ssp_properties

// File: ssp_partner.sv
// Model of the external slave facing the port in master mode
`timescale 1ns/1ps
module ssp_partner (
    input wire logic clk,
    input wire logic sel_n,
    input wire logic sck,
    input wire logic mosi,
    input wire logic clock_phase_select,
    input wire logic [7:0] tx,
    output logic miso,
    output logic [7:0] rx,
    output logic [4:0] edges
);
    // ****************
    // Slave shifter
    // ****************
    logic sck_q = 1'b0;
    logic sel_q = 1'b1;
    logic flip = 1'b0;
    logic [7:0] sh = 8'h00;
    initial rx = 8'h00;
    initial edges = 5'h00;
    assign miso = sel_n ? flip : sh[7];
    always @(posedge clk) begin
        sck_q <= sck;
        sel_q <= sel_n;
        flip <= ~flip;
        if (sel_n) begin
            sh <= tx;
        end else if (sel_q) begin
            edges <= 5'h00;
        end else if (sck != sck_q) begin
            edges <= edges + 5'h01;
            if (edges[0] == clock_phase_select) begin
                rx <= {rx[6:0], mosi};
            end else if (!(clock_phase_select && edges == 5'h00)) begin
                sh <= {sh[6:0], 1'b0};
            end
        end
    end
endmodule // ssp_partner

// File: testbench.sv
// Self-checking bench of the serial port
`timescale 1ns/1ps
module testbench;
    // ****************
    // Signals, tasks, tests
    // ****************
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic wait_mode = 1'b0;
    logic stop_mode = 1'b0;
    logic mosi_b = 1'b0;
    logic ss_b = 1'b1;
    logic sck_b = 1'b0;
    logic p_clock_phase_select = 1'b0;
    logic [7:0] p_tx = 8'h00;
    logic [7:0] rdata, p_rx, got;
    logic mosi_o, mosi_oe, miso_o, miso_oe, ss_n_o, ss_n_oe, sck_o, sck_oe, irq, p_miso;
    logic [4:0] p_edges, e0;
    integer num_errors = 0;
    integer checked = 0;
    wire logic miso_w = miso_oe ? miso_o : p_miso;
    wire logic mosi_w = mosi_oe ? mosi_o : mosi_b;
    wire logic ss_w = ss_n_oe ? ss_n_o : ss_b;
    wire logic sck_w = sck_oe ? sck_o : sck_b;
    spi_serial_port spi_serial_port_i (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .wait_mode(wait_mode), .stop_mode(stop_mode),
        .mosi_i(mosi_w), .mosi_o(mosi_o), .mosi_oe(mosi_oe), .miso_i(miso_w),
        .miso_o(miso_o), .miso_oe(miso_oe), .ss_n_i(ss_w), .ss_n_o(ss_n_o),
        .ss_n_oe(ss_n_oe), .sck_i(sck_w), .sck_o(sck_o), .sck_oe(sck_oe), .irq(irq));
    ssp_partner ssp_partner_i (.clk(clk), .sel_n(ss_n_o), .sck(sck_o), .mosi(mosi_o),
        .clock_phase_select(p_clock_phase_select), .tx(p_tx), .miso(p_miso), .rx(p_rx), .edges(p_edges));
    function automatic logic [7:0] rexp(input logic [3:0] a);
        return (a == ssp_pkg::OFF_CTRL1) ? ssp_pkg::CTRL1_RST : 8'h00;
    endfunction
    function automatic logic [7:0] wexp(input logic [3:0] a);
        if (a == ssp_pkg::OFF_CTRL2) return ssp_pkg::CTRL2_WMASK;
        if (a == ssp_pkg::OFF_BAUD) return ssp_pkg::BAUD_WMASK;
        return 8'h00;
    endfunction
    function automatic logic halted(input int k);
        return k >= 2;
    endfunction
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        checked = checked + 1;
        if (g !== e) begin
            num_errors = num_errors + 1;
            $display("FAIL %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask
    task automatic run_master(input int k, input logic cph, input logic cpl);
        logic [7:0] b;
        logic [7:0] p;
        int n;
        b = $urandom;
        p = $urandom;
        wr_reg(ssp_pkg::OFF_CTRL2, k == 2 ? 8'h12 : 8'h10);
        p_tx <= p;
        p_clock_phase_select <= cph;
        wr_reg(ssp_pkg::OFF_CTRL1, 8'h52 | {4'h0, cpl, cph, 2'h0});
        wr_reg(ssp_pkg::OFF_EVT_MASK, 8'h01);
        #1;
        chk({7'h0, sck_o}, {7'h0, cpl});
        wr_reg(ssp_pkg::OFF_DATA, b);
        repeat (30) @(posedge clk);
        e0 = p_edges;
        wait_mode <= k == 1 || k == 2;
        stop_mode <= k == 3;
        repeat (40) @(posedge clk);
        chk({7'h0, p_edges == e0}, {7'h0, halted(k)});
        wait_mode <= 1'b0;
        stop_mode <= 1'b0;
        n = 0;
        got = 8'h00;
        while (got[7] !== 1'b1 && n < 200) begin
            rd_reg(ssp_pkg::OFF_FLAGS, got);
            n = n + 1;
        end
        chk({7'h0, got[7]}, 8'h01);
        chk({7'h0, irq}, 8'h01);
        rd_reg(ssp_pkg::OFF_EVT, got);
        chk(got & 8'h01, 8'h01);
        rd_reg(ssp_pkg::OFF_DATA, got);
        chk(got, p);
        chk({7'h0, irq}, 8'h00);
        chk(p_rx, b);
        chk({3'h0, p_edges}, 8'h10);
        $display("master test kind %0d done", k);
    endtask
    task automatic run_slave(input logic [7:0] b, input logic [7:0] m);
        logic [7:0] s;
        wr_reg(ssp_pkg::OFF_CTRL2, 8'h00);
        wr_reg(ssp_pkg::OFF_CTRL1, 8'h40);
        wr_reg(ssp_pkg::OFF_DATA, b);
        stop_mode <= 1'b1;
        ss_b = 1'b0;
        #125;
        for (int i = 7; i >= 0; i--) begin
            mosi_b = m[i];
            #62.5;
            s[i] = miso_w;
            sck_b = 1'b1;
            #62.5;
            sck_b = 1'b0;
        end
        #125;
        ss_b = 1'b1;
        mosi_b = ~mosi_b;
        @(posedge clk);
        stop_mode <= 1'b0;
        repeat (8) @(posedge clk);
        chk(s, b);
        rd_reg(ssp_pkg::OFF_DATA, s);
        chk(s, m);
        $display("slave test done");
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        forever #5 clk = ~clk;
    end
    initial begin
        #300000;
        num_errors = num_errors + 1;
        tally_and_finish();
    end
    initial begin
        logic [1:0] md;
        logic [3:0] offs [4];
        offs = '{4'h1, 4'h2, 4'h3, 4'h6};
        void'($urandom(34466));
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        for (int a = 0; a < 16; a++) begin
            rd_reg(4'(a), got);
            chk(got, rexp(4'(a)));
        end
        for (int i = 0; i < 4; i++) begin
            wr_reg(offs[i], 8'hff);
            rd_reg(offs[i], got);
            chk(got, wexp(offs[i]));
        end
        $display("register test done");
        wr_reg(ssp_pkg::OFF_BAUD, 8'h70);
        for (int i = 0; i < 8; i++) begin
            md = (i < 4) ? i[1:0] : 2'($urandom);
            run_master(i < 4 ? i : 0, md[0], md[1]);
        end
        wr_reg(ssp_pkg::OFF_CTRL1, 8'h10);
        rd_reg(ssp_pkg::OFF_FLAGS, got);
        chk(got, 8'h00);
        chk({7'h0, sck_oe}, 8'h00);
        $display("disable test done");
        run_slave($urandom, $urandom);
        run_slave(8'h00, 8'hff);
        tally_and_finish();
    end
endmodule // testbench
bind spi_serial_port ssp_properties ssp_properties_i (.clk(clk), .rst(rst), .addr(addr),
    .rd(rd), .rdata(rdata), .stop_mode(stop_mode), .ss_n_i(ss_n_i), .mosi_o(mosi_o),
    .miso_oe(miso_oe), .ss_n_o(ss_n_o), .ss_n_oe(ss_n_oe), .sck_o(sck_o), .sck_oe(sck_oe));
